/* logic/smosd_top.sv */
// Stop mode control and crystal oscillator stop detector.
// Assumes synchronous peripheral interrupt pulses, a crystal sampled
// on sys_clk and an AXI4-Lite master that waits for each answer.
// Operation
// (RQ1) Stop halts all oscillators except watchdog one
// (RQ2) Externally clocked peripherals keep running in stop
// (RQ3) Key always wakes; ext lines unfiltered only
// (RQ4) Timer RA wakes only unfiltered event counting
// (RQ5) Serial wakes only with external clock
// (RQ6) Voltage monitors wake only with filter off
// (RQ7) Writing stop bit enters stop mode
// (RQ8) Entering stop forces divide-by-8 select
// (RQ9) Software clears detect enable and override first
// (RQ10) Software clears low-current read before stop
// (RQ11) Ports hold; crystal output high or input
// (RQ12) Reset or enabled interrupt leaves stop
// (RQ13) Software prepares priorities and enables before stop
// (RQ14) Interrupt sequence runs after clock restarts
// (RQ15) Wake CPU clock is old source over 8
// (RQ16) Detector works only with enable 11b
// (RQ17) Crystal stop selects on-chip clock, flags, irq
// (RQ18) Shared vector; source bits identify oscillator stop
// (RQ19) Watchdog and monitors set own flags
// (RQ20) No automatic return to the crystal
// (RQ21) Software keeps peripheral wait stop at 0
// (RQ22) Software disables detector around crystal changes
// (RQ23) Software picks fallback oscillator before enabling
// (RQ24) Hardware clears stop bit on leaving stop
//
// Implementation choices: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
module smosd_top (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [11:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  input wire smosd_pkg::smosd_wake_src_s wake_src,
  input wire logic wdt_underflow,
  input wire logic crystal_input_clock,
  output var smosd_pkg::smosd_osc_en_s osc_en,
  output var smosd_pkg::smosd_clk_src_e cpu_clk_src,
  output logic [2:0] cpu_div_log2,
  output logic cpu_clk_en,
  output logic periph_clk_en,
  output logic ext_periph_clk_en,
  output logic port_hold,
  output logic crystal_output_pin_o,
  output logic crystal_output_pin_oe,
  output logic wake_irq_req,
  output logic shared_irq
);

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  smosd_pkg::smosd_state_e state_reg, state_next;
  smosd_pkg::smosd_cnt_t wake_cnt_reg, wake_cnt_next;
  smosd_pkg::smosd_cnt_t stall_cnt_reg, stall_cnt_next;
  logic [15:0] ctrl_reg, ctrl_next;
  logic [15:0] wake_cfg_reg, wake_cfg_next;
  logic [1:0] ocd_en_reg, ocd_en_next;
  logic onchip_reg, onchip_next;
  logic xtal_prev_reg;
  logic wake_req_reg, wake_req_next;
  logic stopped_flag, wdt_flag, vm1_flag, vm2_flag;
  logic wr_fire, rd_fire, wr_ctrl, wr_ocd, wr_wake, wr_flag, wr_hit;
  logic bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
  logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [15:0] wr_mask;
  logic wake_any, det_active, xtal_stall, osc_stop_evt, osc_src;

  // ------------------------------------------------------------------
  // Bus decode
  // ------------------------------------------------------------------
  // Address and data are taken together; only one write in flight
  assign wr_fire = s_axi_awvalid && s_axi_wvalid && !bvalid_reg;
  assign rd_fire = s_axi_arvalid && !rvalid_reg;
  assign s_axi_awready = wr_fire;
  assign s_axi_wready = wr_fire;
  assign s_axi_arready = rd_fire;
  assign wr_ctrl = wr_fire && (s_axi_awaddr == smosd_pkg::CTRL_OFS);
  assign wr_ocd = wr_fire && (s_axi_awaddr == smosd_pkg::OCD_OFS);
  assign wr_wake = wr_fire && (s_axi_awaddr == smosd_pkg::WAKE_OFS);
  assign wr_flag = wr_fire && (s_axi_awaddr == smosd_pkg::FLAG_OFS);
  assign wr_hit = wr_ctrl || wr_ocd || wr_wake || wr_flag;
  // Registers are 16 bits wide, so only the low two lanes matter
  assign wr_mask = {{8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};

  // ------------------------------------------------------------------
  // Wake qualification
  // ------------------------------------------------------------------
  // Filters and internal clocks are dead in stop, so only sources
  // that need neither may wake; priorities and the global enable are
  // prepared by software beforehand [RQ13]
  always_comb begin
    wake_any = wake_src.key; // [RQ3]
    wake_any = wake_any || |(wake_src.ext & wake_cfg_reg[3:0]); // [RQ3]
    wake_any = wake_any || (wake_src.timer_ra && wake_cfg_reg[smosd_pkg::WK_RA_EVENT]
                            && wake_cfg_reg[smosd_pkg::WK_RA_NOFILT]); // [RQ4]
    wake_any = wake_any || (wake_src.serial && wake_cfg_reg[smosd_pkg::WK_SER_EXTCLK]); // [RQ5]
    wake_any = wake_any || (wake_src.vmon1 && wake_cfg_reg[smosd_pkg::WK_VM1_NOFILT]); // [RQ6]
    wake_any = wake_any || (wake_src.vmon2 && wake_cfg_reg[smosd_pkg::WK_VM2_NOFILT]); // [RQ6]
  end

  // ------------------------------------------------------------------
  // Oscillator stop detector
  // ------------------------------------------------------------------
  // Armed only by the full enable code and only in the run state;
  // software turns it off around its own crystal changes [RQ22]
  assign det_active = (ocd_en_reg == smosd_pkg::OCD_EN_ON) &&
                      (state_reg == smosd_pkg::SMOSD_RUN); // [RQ16]
  assign xtal_stall = (stall_cnt_reg == smosd_pkg::XSTOP_CNT);
  // Only a crystal that feeds the CPU raises the event
  assign osc_stop_evt = det_active && xtal_stall && !onchip_reg; // [RQ17]

  // Silence counter; any crystal edge restarts it
  always_comb begin
    stall_cnt_next = stall_cnt_reg;
    if (!det_active || (crystal_input_clock != xtal_prev_reg)) begin
      stall_cnt_next = '0; // [RQ16]
    end else if (!xtal_stall) begin
      stall_cnt_next = stall_cnt_reg + smosd_pkg::smosd_cnt_t'(1);
    end
  end

  // ------------------------------------------------------------------
  // Control registers and power state
  // ------------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    wake_cnt_next = wake_cnt_reg;
    ctrl_next = ctrl_reg;
    wake_cfg_next = wake_cfg_reg;
    ocd_en_next = ocd_en_reg;
    onchip_next = onchip_reg;
    wake_req_next = 1'b0;
    // Software writes first, hardware events override below
    if (wr_ctrl) begin
      ctrl_next = (ctrl_reg & ~wr_mask) | (s_axi_wdata[15:0] & wr_mask);
    end
    if (wr_wake) begin
      wake_cfg_next = (wake_cfg_reg & ~wr_mask) | (s_axi_wdata[15:0] & wr_mask);
    end
    if (wr_ocd && s_axi_wstrb[0]) begin
      ocd_en_next = s_axi_wdata[1:0];
      // Only software returns the CPU to the crystal
      onchip_next = s_axi_wdata[smosd_pkg::OCD_ONCHIP]; // [RQ20]
    end
    if (osc_stop_evt) begin
      onchip_next = 1'b1; // [RQ17]
      ctrl_next[smosd_pkg::CTRL_LSO_OFF] = 1'b0; // [RQ17]
    end
    unique case (state_reg)
      smosd_pkg::SMOSD_RUN: begin
        // Detector and override are assumed cleared, low-current
        // read off, before the request [RQ9] [RQ10]
        if (ctrl_reg[smosd_pkg::CTRL_STOP]) begin
          state_next = smosd_pkg::SMOSD_STOP; // [RQ7]
          ctrl_next[smosd_pkg::CTRL_DIV8] = 1'b1; // [RQ8]
        end
      end
      smosd_pkg::SMOSD_STOP: begin
        if (wake_any) begin
          state_next = smosd_pkg::SMOSD_WAKE; // [RQ12]
          wake_cnt_next = smosd_pkg::WAKE_CNT;
        end
      end
      smosd_pkg::SMOSD_WAKE: begin
        // Oscillators settle before the CPU clock is released
        if (wake_cnt_reg == '0) begin
          state_next = smosd_pkg::SMOSD_RUN;
          wake_req_next = 1'b1; // [RQ14]
          ctrl_next[smosd_pkg::CTRL_STOP] = 1'b0; // [RQ24]
        end else begin
          wake_cnt_next = wake_cnt_reg - smosd_pkg::smosd_cnt_t'(1);
        end
      end
      default: begin
        state_next = smosd_pkg::SMOSD_RUN;
      end
    endcase
  end

  // Reset always lands in run with the stop bit clear [RQ12] [RQ24]
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= smosd_pkg::SMOSD_RUN;
      wake_cnt_reg <= '0;
      stall_cnt_reg <= '0;
      ctrl_reg <= smosd_pkg::CTRL_RST;
      wake_cfg_reg <= smosd_pkg::WAKE_RST;
      ocd_en_reg <= 2'h0;
      onchip_reg <= 1'b0;
      xtal_prev_reg <= 1'b0;
      wake_req_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      wake_cnt_reg <= wake_cnt_next;
      stall_cnt_reg <= stall_cnt_next;
      ctrl_reg <= ctrl_next;
      wake_cfg_reg <= wake_cfg_next;
      ocd_en_reg <= ocd_en_next;
      onchip_reg <= onchip_next;
      xtal_prev_reg <= crystal_input_clock;
      wake_req_reg <= wake_req_next;
    end
  end

  // ------------------------------------------------------------------
  // Status flags
  // ------------------------------------------------------------------
  // Writing 0 to the stopped bit clears it; flags clear on write of 1
  smosd_flag u_stopped (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .set(osc_stop_evt), // [RQ17]
    .clr(wr_ocd && s_axi_wstrb[0] && !s_axi_wdata[smosd_pkg::OCD_STOPPED]),
    .q(stopped_flag)
  );
  smosd_flag u_wdt (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .set(wdt_underflow), // [RQ19]
    .clr(wr_flag && s_axi_wstrb[0] && s_axi_wdata[smosd_pkg::FL_WDT]),
    .q(wdt_flag)
  );
  smosd_flag u_vm1 (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .set(wake_src.vmon1), // [RQ19]
    .clr(wr_flag && s_axi_wstrb[0] && s_axi_wdata[smosd_pkg::FL_VM1]),
    .q(vm1_flag)
  );
  smosd_flag u_vm2 (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .set(wake_src.vmon2), // [RQ19]
    .clr(wr_flag && s_axi_wstrb[0] && s_axi_wdata[smosd_pkg::FL_VM2]),
    .q(vm2_flag)
  );

  // ------------------------------------------------------------------
  // Clock and pin outputs
  // ------------------------------------------------------------------
  // Every oscillator but the watchdog one dies in stop [RQ1]
  assign osc_en.xtal = (state_reg == smosd_pkg::SMOSD_RUN || state_reg == smosd_pkg::SMOSD_WAKE)
                       && !ctrl_reg[smosd_pkg::CTRL_XHALT] && !onchip_reg; // [RQ1]
  assign osc_en.lso = (state_reg != smosd_pkg::SMOSD_STOP) && !ctrl_reg[smosd_pkg::CTRL_LSO_OFF];
  assign osc_en.hso = (state_reg != smosd_pkg::SMOSD_STOP) && ctrl_reg[smosd_pkg::CTRL_HS_RUN];
  assign osc_en.wdt = 1'b1; // [RQ1]
  assign cpu_clk_en = (state_reg == smosd_pkg::SMOSD_RUN); // [RQ1]
  assign periph_clk_en = (state_reg == smosd_pkg::SMOSD_RUN); // [RQ1]
  // Externally clocked peripherals never lose their enable
  assign ext_periph_clk_en = 1'b1; // [RQ2]
  // Fallback oscillator is whichever software picked up front [RQ23]
  assign cpu_clk_src = !onchip_reg ? smosd_pkg::SMOSD_SRC_XTAL :
                       ctrl_reg[smosd_pkg::CTRL_HS_SEL] ? smosd_pkg::SMOSD_SRC_HSO :
                       smosd_pkg::SMOSD_SRC_LSO; // [RQ20]
  // Source is untouched across stop, so wake resumes it over 8 [RQ15]
  always_comb begin
    unique case ({ctrl_reg[smosd_pkg::CTRL_DIV_HI], ctrl_reg[smosd_pkg::CTRL_DIV_LO]})
      2'h0: cpu_div_log2 = smosd_pkg::DIV_LOG2_1;
      2'h1: cpu_div_log2 = smosd_pkg::DIV_LOG2_2;
      2'h2: cpu_div_log2 = smosd_pkg::DIV_LOG2_4;
      2'h3: cpu_div_log2 = smosd_pkg::DIV_LOG2_16;
    endcase
    if (ctrl_reg[smosd_pkg::CTRL_DIV8]) begin
      cpu_div_log2 = smosd_pkg::DIV_LOG2_8; // [RQ15]
    end
  end
  assign port_hold = (state_reg != smosd_pkg::SMOSD_RUN); // [RQ11]
  assign crystal_output_pin_o = 1'b1;
  assign crystal_output_pin_oe = port_hold && ctrl_reg[smosd_pkg::CTRL_XPIN]; // [RQ11]
  assign wake_irq_req = wake_req_reg;
  // One vector for oscillator stop, watchdog and both monitors
  assign osc_src = stopped_flag || ((ocd_en_reg == smosd_pkg::OCD_EN_ON) && onchip_reg); // [RQ18]
  assign shared_irq = osc_src || wdt_flag || vm1_flag || vm2_flag; // [RQ18]

  // ------------------------------------------------------------------
  // Bus answers
  // ------------------------------------------------------------------
  // Unmapped addresses answer SLVERR, reads of them return zero
  always_comb begin
    bvalid_next = bvalid_reg && !s_axi_bready;
    bresp_next = bresp_reg;
    rvalid_next = rvalid_reg && !s_axi_rready;
    rresp_next = rresp_reg;
    rdata_next = rdata_reg;
    if (wr_fire) begin
      bvalid_next = 1'b1;
      bresp_next = wr_hit ? smosd_pkg::RESP_OKAY : smosd_pkg::RESP_SLVERR;
    end
    if (rd_fire) begin
      rvalid_next = 1'b1;
      rresp_next = smosd_pkg::RESP_OKAY;
      unique case (s_axi_araddr)
        smosd_pkg::CTRL_OFS: rdata_next = {16'h0000, ctrl_reg};
        smosd_pkg::OCD_OFS: rdata_next = {28'h0000000, stopped_flag, onchip_reg, ocd_en_reg};
        smosd_pkg::WAKE_OFS: rdata_next = {16'h0000, wake_cfg_reg};
        smosd_pkg::FLAG_OFS: rdata_next = {29'h0000000, vm2_flag, vm1_flag, wdt_flag};
        smosd_pkg::STAT_OFS: rdata_next = {24'h000000, osc_src, cpu_clk_src, cpu_div_log2, state_reg};
        default: begin
          rdata_next = 32'h00000000;
          rresp_next = smosd_pkg::RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= smosd_pkg::RESP_OKAY;
      rvalid_reg <= 1'b0;
      rresp_reg <= smosd_pkg::RESP_OKAY;
      rdata_reg <= 32'h00000000;
    end else begin
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      rvalid_reg <= rvalid_next;
      rresp_reg <= rresp_next;
      rdata_reg <= rdata_next;
    end
  end

  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rresp = rresp_reg;
  assign s_axi_rdata = rdata_reg;

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  sequence s_restart;
    (state_reg == smosd_pkg::SMOSD_WAKE && !cpu_clk_en)[*6] ##1 (cpu_clk_en && wake_irq_req);
  endsequence
  property p_stop_entry;
    state_reg == smosd_pkg::SMOSD_RUN && ctrl_reg[smosd_pkg::CTRL_STOP]
      |=> state_reg == smosd_pkg::SMOSD_STOP && cpu_div_log2 == smosd_pkg::DIV_LOG2_8;
  endproperty
  a_stop_entry: assert property (p_stop_entry) else $error("stop not entered at div8"); // [RQ7]
  property p_clocks_off;
    state_reg == smosd_pkg::SMOSD_STOP |-> !cpu_clk_en && !periph_clk_en && !osc_en.xtal
      && !osc_en.lso && !osc_en.hso && osc_en.wdt && ext_periph_clk_en;
  endproperty
  a_clocks_off: assert property (p_clocks_off) else $error("clock running in stop"); // [RQ1]
  property p_key_wake;
    state_reg == smosd_pkg::SMOSD_STOP && wake_src.key |=> state_reg == smosd_pkg::SMOSD_WAKE;
  endproperty
  a_key_wake: assert property (p_key_wake) else $error("key did not wake"); // [RQ3]
  property p_ra_blocked;
    state_reg == smosd_pkg::SMOSD_STOP && !wake_cfg_reg[smosd_pkg::WK_RA_NOFILT]
      && wake_src == smosd_pkg::smosd_wake_src_s'(9'h008) |=> state_reg == smosd_pkg::SMOSD_STOP;
  endproperty
  a_ra_blocked: assert property (p_ra_blocked) else $error("filtered timer woke"); // [RQ4]
  property p_wake_seq;
    state_reg == smosd_pkg::SMOSD_STOP && wake_any |=> s_restart;
  endproperty
  a_wake_seq: assert property (p_wake_seq) else $error("wake sequence wrong"); // [RQ14]
  property p_wake_clock;
    wake_irq_req |-> cpu_div_log2 == smosd_pkg::DIV_LOG2_8 && !ctrl_reg[smosd_pkg::CTRL_STOP]
      && cpu_clk_src == $past(cpu_clk_src, 8);
  endproperty
  a_wake_clock: assert property (p_wake_clock) else $error("wake clock wrong"); // [RQ15]
  property p_pin_hold;
    state_reg == smosd_pkg::SMOSD_STOP |-> port_hold
      && crystal_output_pin_oe == ctrl_reg[smosd_pkg::CTRL_XPIN];
  endproperty
  a_pin_hold: assert property (p_pin_hold) else $error("pins not held"); // [RQ11]
  property p_det_off;
    ocd_en_reg != smosd_pkg::OCD_EN_ON |=> stall_cnt_reg == '0 && !$rose(stopped_flag);
  endproperty
  a_det_off: assert property (p_det_off) else $error("detector active while off"); // [RQ16]
  property p_osc_stop;
    osc_stop_evt |=> onchip_reg && stopped_flag && !ctrl_reg[smosd_pkg::CTRL_LSO_OFF] && shared_irq;
  endproperty
  a_osc_stop: assert property (p_osc_stop) else $error("stop reaction missing"); // [RQ17]
  property p_no_return;
    onchip_reg && !wr_ocd |=> onchip_reg;
  endproperty
  a_no_return: assert property (p_no_return) else $error("auto return to crystal"); // [RQ20]
  property p_wdt_flag;
    wdt_underflow |=> wdt_flag && shared_irq;
  endproperty
  a_wdt_flag: assert property (p_wdt_flag) else $error("watchdog flag not set"); // [RQ19]

endmodule
`default_nettype wire

/* logic/smosd_pkg.sv */
// Constants and carrier types for the stop mode / oscillator stop block.
// Assumes a single 20 MHz system clock and an AXI4-Lite register port.
package smosd_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned SYS_CLK_HZ = 20_000_000;
  localparam int unsigned SYS_PERIOD_NS = 1_000_000_000 / SYS_CLK_HZ;
  // Crystal silence treated as a stop: one period at the 2 MHz floor
  localparam int unsigned XSTOP_TIME_NS = 500;
  localparam int unsigned XSTOP_CYC = (XSTOP_TIME_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
  // Oscillator restart settle before the CPU clock returns
  localparam int unsigned WAKE_TIME_NS = 250;
  localparam int unsigned WAKE_CYC = (WAKE_TIME_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
  typedef logic [4:0] smosd_cnt_t;
  localparam smosd_cnt_t XSTOP_CNT = smosd_cnt_t'(XSTOP_CYC);
  localparam smosd_cnt_t WAKE_CNT = smosd_cnt_t'(WAKE_CYC);

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  typedef logic [11:0] smosd_addr_t;
  localparam smosd_addr_t CTRL_OFS = 12'h000;
  localparam smosd_addr_t OCD_OFS = 12'h004;
  localparam smosd_addr_t WAKE_OFS = 12'h008;
  localparam smosd_addr_t FLAG_OFS = 12'h00c;
  localparam smosd_addr_t STAT_OFS = 12'h010;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Control register bits
  localparam int CTRL_STOP = 0;
  localparam int CTRL_DIV8 = 1;
  localparam int CTRL_DIV_LO = 2;
  localparam int CTRL_DIV_HI = 3;
  localparam int CTRL_XPIN = 4;
  localparam int CTRL_LSO_OFF = 5;
  localparam int CTRL_WAKE_OVR = 6;
  localparam int CTRL_XHALT = 7;
  localparam int CTRL_PSTOP_WAIT = 8;
  localparam int CTRL_HS_RUN = 9;
  localparam int CTRL_HS_SEL = 10;
  localparam int CTRL_LCR_EN = 11;
  localparam logic [15:0] CTRL_RST = 16'h0000;
  // Oscillator stop detect register bits
  localparam int OCD_ONCHIP = 2;
  localparam int OCD_STOPPED = 3;
  localparam logic [1:0] OCD_EN_ON = 2'h3;
  // Wake qualification register bits (ext filter off in 3:0)
  localparam int WK_RA_EVENT = 4;
  localparam int WK_RA_NOFILT = 5;
  localparam int WK_SER_EXTCLK = 6;
  localparam int WK_VM1_NOFILT = 7;
  localparam int WK_VM2_NOFILT = 8;
  localparam logic [15:0] WAKE_RST = 16'h0000;
  // Flag register bits
  localparam int FL_WDT = 0;
  localparam int FL_VM1 = 1;
  localparam int FL_VM2 = 2;
  // CPU divider as log2 of the ratio
  localparam logic [2:0] DIV_LOG2_1 = 3'h0;
  localparam logic [2:0] DIV_LOG2_2 = 3'h1;
  localparam logic [2:0] DIV_LOG2_4 = 3'h2;
  localparam logic [2:0] DIV_LOG2_8 = 3'h3;
  localparam logic [2:0] DIV_LOG2_16 = 3'h4;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SMOSD_RUN = 2'h0,
    SMOSD_STOP = 2'h1,
    SMOSD_WAKE = 2'h3
  } smosd_state_e;

  typedef enum logic [1:0] {
    SMOSD_SRC_XTAL = 2'h0,
    SMOSD_SRC_LSO = 2'h1,
    SMOSD_SRC_HSO = 2'h2
  } smosd_clk_src_e;

  typedef struct packed {
    logic key;
    logic [3:0] ext;
    logic timer_ra;
    logic serial;
    logic vmon1;
    logic vmon2;
  } smosd_wake_src_s;

  typedef struct packed {
    logic xtal;
    logic lso;
    logic hso;
    logic wdt;
  } smosd_osc_en_s;

endpackage

/* logic/smosd_flag.sv */
// Sticky status flag: hardware set, software clear.
// Assumes set and clear are single-cycle qualified strobes.
`timescale 1ns/1ns
`default_nettype none
module smosd_flag (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic set,
  input wire logic clr,
  output logic q
);

  logic q_next;

  // Set wins so an event in the clearing cycle is kept
  always_comb begin
    q_next = q;
    if (clr) begin
      q_next = 1'b0;
    end
    if (set) begin
      q_next = 1'b1;
    end
  end

  // Flag storage
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      q <= 1'b0;
    end else begin
      q <= q_next;
    end
  end

endmodule
`default_nettype wire

/* tb/smosd_xtal_model.sv */
// Crystal oscillator model feeding crystal_input_clock.
// Assumes sys_clk at 20 MHz; output toggles each cycle while run.
`timescale 1ns/1ns
`default_nettype none
module smosd_xtal_model (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic run,
  output logic crystal_input_clock
);
  // Level freezes on a stop, as a dead crystal would
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) crystal_input_clock <= 1'b0;
    else if (run) crystal_input_clock <= ~crystal_input_clock;
  end
endmodule
`default_nettype wire

/* tb/tb_stop_mode_and_osc_stop_detect.sv */
// Bench for stop mode control and oscillator stop detect.
// Assumes smosd_top and the crystal model; AXI4-Lite master tasks.
`timescale 1ns/1ns
`default_nettype none
module tb_stop_mode_and_osc_stop_detect;
  logic sys_clk = 1'b0, nrst = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic [31:0] wdata = 32'h0, rdata, rd, r;
  logic awready, bvalid, rvalid, cpu_clk_en, port_hold, pin_oe, wake_irq_req, shared_irq;
  logic arready, crystal_input_clock;
  logic wdt = 1'b0, xrun = 1'b1;
  logic [1:0] bresp, rresp, rs;
  logic [2:0] div;
  smosd_pkg::smosd_wake_src_s ws = '0;
  int error_cnt = 0, checks = 0, seed = 32'h11ea6e10, n = 0;
  smosd_top dut (.sys_clk(sys_clk), .nrst(nrst), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid), .s_axi_wready(), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_araddr(araddr), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .wake_src(ws), .wdt_underflow(wdt),
    .crystal_input_clock(crystal_input_clock),
    .osc_en(), .cpu_clk_src(), .cpu_div_log2(div), .cpu_clk_en(cpu_clk_en), .periph_clk_en(),
    .ext_periph_clk_en(), .port_hold(port_hold), .crystal_output_pin_o(), .crystal_output_pin_oe(pin_oe),
    .wake_irq_req(wake_irq_req), .shared_irq(shared_irq));
  smosd_xtal_model xtal (.sys_clk(sys_clk), .nrst(nrst), .run(xrun), .crystal_input_clock(crystal_input_clock));
  // ----
  // Bus and check tasks
  // ----
  task automatic end_of_test();
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // One clock with a hang guard
  task automatic step();
    @(posedge sys_clk);
    n++;
    if (n > 300) begin
      error_cnt++;
      end_of_test();
    end
  endtask
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", s, e, g);
    end
  endtask
  // Address and data offered together, bready held until bvalid
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    n = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do step(); while (awready !== 1'b1);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    do step(); while (bvalid !== 1'b1);
    rs = bresp;
  endtask
  // Ready lines stay up between transfers, so calls may follow back to back
  task automatic rd_t(input logic [11:0] a);
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do step(); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do step(); while (rvalid !== 1'b1);
    rd = rdata;
    rs = rresp;
  endtask
  initial begin
    forever #25 sys_clk = ~sys_clk;
  end
  // Main sequence; stop settles one cycle after the write is taken
  initial begin
    repeat (16) @(posedge sys_clk);
    nrst <= 1'b1;
    rd_t(12'h020);
    chk("unmapped resp", 32'h2, 32'(rs));
    wr(12'h020, 32'h1);
    chk("unmapped wr resp", 32'h2, 32'(rs));
    r = $random(seed) & 32'h1ff;
    wr(smosd_pkg::WAKE_OFS, r);
    chk("wake wr resp", 32'h0, 32'(rs));
    rd_t(smosd_pkg::WAKE_OFS);
    chk("wake cfg", r, rd);
    wr(smosd_pkg::WAKE_OFS, 32'h0);
    wr(smosd_pkg::OCD_OFS, 32'h0);
    wr(smosd_pkg::CTRL_OFS, 32'h11);
    repeat (3) step();
    chk("port hold", 32'h1, 32'(port_hold));
    chk("crystal_output_pin drive", 32'h1, 32'(pin_oe));
    chk("cpu clock", 32'h0, 32'(cpu_clk_en));
    chk("divider", 32'h3, 32'(div));
    ws.ext <= 4'($random(seed)) | 4'h1;
    step();
    ws.ext <= 4'h0;
    ws.timer_ra <= 1'b1;
    step();
    ws.timer_ra <= 1'b0;
    repeat (10) step();
    chk("filtered ext", 32'h1, 32'(port_hold));
    ws.key <= 1'b1;
    step();
    ws.key <= 1'b0;
    n = 0;
    do step(); while (wake_irq_req !== 1'b1);
    chk("clock back", 32'h1, 32'(cpu_clk_en));
    rd_t(smosd_pkg::CTRL_OFS);
    chk("ctrl after wake", 32'h12, rd);
    rd_t(smosd_pkg::STAT_OFS);
    chk("status after wake", 32'h0c, rd);
    xrun <= 1'b0;
    repeat (20) step();
    chk("detect off", 32'h0, 32'(shared_irq));
    wr(smosd_pkg::OCD_OFS, 32'h3);
    do step(); while (shared_irq !== 1'b1);
    rd_t(smosd_pkg::OCD_OFS);
    chk("detect bits", 32'hf, rd);
    rd_t(smosd_pkg::STAT_OFS);
    chk("osc source", 32'hac, rd);
    xrun <= 1'b1;
    repeat (20) step();
    rd_t(smosd_pkg::OCD_OFS);
    chk("no auto return", 32'hf, rd);
    wdt <= 1'b1;
    ws.vmon1 <= 1'b1;
    step();
    wdt <= 1'b0;
    ws.vmon1 <= 1'b0;
    rd_t(smosd_pkg::FLAG_OFS);
    chk("flags", 32'h3, rd);
    // Second stop, left by a reset in mid-stop
    wr(smosd_pkg::OCD_OFS, 32'h0);
    wr(smosd_pkg::CTRL_OFS, 32'h1);
    repeat (3) step();
    chk("stop before reset", 32'h0, 32'(cpu_clk_en));
    nrst <= 1'b0;
    repeat (4) step();
    nrst <= 1'b1;
    chk("clock in reset", 32'h1, 32'(cpu_clk_en));
    rd_t(smosd_pkg::CTRL_OFS);
    chk("ctrl after reset", 32'h0, rd);
    end_of_test();
  end
endmodule
`default_nettype wire
